// ==== core/ssx_consts.vh ====
// Constants for the subtract, swap, xor and sleep execution block
`ifndef SSX_CONSTS_VH
`define SSX_CONSTS_VH
// Register byte offsets
`define SSX_OFS_CMD      6'h00
`define SSX_OFS_ACC      6'h04
`define SSX_OFS_FILE     6'h08
`define SSX_OFS_STAT     6'h0c
`define SSX_OFS_WDOG     6'h10
// Command fields
`define SSX_CMD_OP       2:0
`define SSX_CMD_DEST     3
`define SSX_CMD_FADDR    14:8
`define SSX_CMD_LIT      23:16
// Operation codes
`define SSX_OP_NONE      3'h0
`define SSX_OP_SLEEP     3'h1
`define SSX_OP_LIT_SUB   3'h2
`define SSX_OP_FILE_SUB  3'h3
`define SSX_OP_NIB_SWAP  3'h4
`define SSX_OP_LIT_XOR   3'h5
`define SSX_OP_FILE_XOR  3'h6
// Status bit positions
`define SSX_ST_C         0
`define SSX_ST_DC        1
`define SSX_ST_Z         2
`define SSX_ST_PD        3
`define SSX_ST_TO        4
`define SSX_ST_SLP       5
// Destination select values
`define SSX_DEST_ACC     1'b0
// Reset values, prescaler step and limit, bus transfer-type bit index
`define SSX_RST_BYTE     8'h00
`define SSX_RST_PRE      8'h00
`define SSX_WDOG_CLR     8'h00
`define SSX_RST_FADDR    7'h00
`define SSX_ZERO32       32'h0000_0000
`define SSX_PRE_ONE      8'h01
`define SSX_PRE_MAX      8'hff
`define SSX_HTRANS_NSEQ  1
`endif

// ==== core/ssx_exec.v ====
// Execution of subtract, nibble swap, exclusive-or and sleep with AHB-Lite registers
`timescale 1ns/1ps
`include "ssx_consts.vh"

// Notes on behaviour
// - sleep clears powerdown, sets timeout flag
// - sleep zeroes watchdog counter and prescaler
// - after sleep, core halts with oscillator stopped
// - literal minus accumulator into accumulator, flags
// - file minus accumulator, routed by destination
// - destination zero accumulator, one file register
// - swap file nibbles, no flag changes
// - literal xor accumulator, zero flag only
// - file xor accumulator, routed, zero flag only
module ssx_exec (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [7:0]  acc_out,
    output reg         file_we,
    output reg  [6:0]  file_addr,
    output reg  [7:0]  file_wdata,
    output reg         wdt_clr,
    output reg         osc_stop
);

////////////////////////////////////////////////////////////////////////////////
// Bus request capture

reg        dph_q;
reg        dwr_q;
reg [5:0]  dadr_q;
wire       take;

assign take = hsel & hready & htrans[`SSX_HTRANS_NSEQ];

// Latch address phase, insert one wait state
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        dph_q     <= 1'b0;
        dwr_q     <= 1'b0;
        dadr_q    <= 6'h00;
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end else if (clk_en) begin
        hresp <= 1'b0;
        if (dph_q) begin
            dph_q     <= 1'b0;
            hreadyout <= 1'b1;
        end else if (take) begin
            dph_q     <= 1'b1;
            dwr_q     <= hwrite;
            dadr_q    <= haddr[5:0];
            hreadyout <= 1'b0;
        end
    end
end

wire wr_en;
wire wr_cmd;
wire wr_acc;
wire wr_file;
wire wr_stat;

assign wr_en   = dph_q & dwr_q;
assign wr_cmd  = wr_en & (dadr_q == `SSX_OFS_CMD);
assign wr_acc  = wr_en & (dadr_q == `SSX_OFS_ACC);
assign wr_file = wr_en & (dadr_q == `SSX_OFS_FILE);
assign wr_stat = wr_en & (dadr_q == `SSX_OFS_STAT);

////////////////////////////////////////////////////////////////////////////////
// Core state

reg  [7:0] acc_q;
reg  [7:0] fop_q;
reg        c_q;
reg        dc_q;
reg        z_q;
reg        pd_n_q;
reg        to_n_q;
reg        slp_q;
reg  [7:0] wdog_q;
reg  [7:0] pre_q;

// Command decode
wire [2:0] op;
wire       dest;
wire [7:0] lit;
wire [6:0] faddr;
wire       go;

assign op    = hwdata[`SSX_CMD_OP];
assign dest  = hwdata[`SSX_CMD_DEST];
assign lit   = hwdata[`SSX_CMD_LIT];
assign faddr = hwdata[`SSX_CMD_FADDR];
// Commands are ignored while the core sleeps
assign go    = wr_cmd & ~slp_q;

////////////////////////////////////////////////////////////////////////////////
// Datapath

reg  [7:0] sub_a;
wire [8:0] dif;
wire [4:0] ldif;
wire [7:0] swp;
wire [7:0] xr_l;
wire [7:0] xr_f;

// Minuend is the literal or the file operand
always @* begin
    sub_a = (op == `SSX_OP_LIT_SUB) ? lit : fop_q;
end

// Two's complement subtract with borrow
assign dif  = {1'b0, sub_a} - {1'b0, acc_q};
assign ldif = {1'b0, sub_a[3:0]} - {1'b0, acc_q[3:0]};
assign swp  = {fop_q[3:0], fop_q[7:4]};
assign xr_l = acc_q ^ lit;
assign xr_f = acc_q ^ fop_q;

// Result selection and flag effects
reg  [7:0] res;
reg        has_res;
reg        route;
reg        upd_cdc;
reg        upd_z;

always @* begin
    res     = `SSX_RST_BYTE;
    has_res = 1'b0;
    route   = 1'b0;
    upd_cdc = 1'b0;
    upd_z   = 1'b0;
    case (op)
        `SSX_OP_LIT_SUB: begin
            res     = dif[7:0];
            has_res = 1'b1;
            upd_cdc = 1'b1;
            upd_z   = 1'b1;
        end
        `SSX_OP_FILE_SUB: begin
            res     = dif[7:0];
            has_res = 1'b1;
            route   = 1'b1;
            upd_cdc = 1'b1;
            upd_z   = 1'b1;
        end
        `SSX_OP_NIB_SWAP: begin
            res     = swp;
            has_res = 1'b1;
            route   = 1'b1;
        end
        `SSX_OP_LIT_XOR: begin
            res     = xr_l;
            has_res = 1'b1;
            upd_z   = 1'b1;
        end
        `SSX_OP_FILE_XOR: begin
            res     = xr_f;
            has_res = 1'b1;
            route   = 1'b1;
            upd_z   = 1'b1;
        end
        default: begin
            res     = `SSX_RST_BYTE;
            has_res = 1'b0;
        end
    endcase
end

// Where the result goes
wire to_file;
wire to_acc;

assign to_file = go & has_res & route & (dest != `SSX_DEST_ACC);
assign to_acc  = go & has_res & ~to_file;
wire   do_slp;
assign do_slp  = go & (op == `SSX_OP_SLEEP);

////////////////////////////////////////////////////////////////////////////////
// Accumulator, file operand and flags

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        acc_q <= `SSX_RST_BYTE;
        fop_q <= `SSX_RST_BYTE;
        c_q   <= 1'b0;
        dc_q  <= 1'b0;
        z_q   <= 1'b0;
    end else if (clk_en) begin
        if (to_acc)
            acc_q <= res;
        else if (wr_acc)
            acc_q <= hwdata[7:0];
        if (to_file)
            fop_q <= res;
        else if (wr_file)
            fop_q <= hwdata[7:0];
        if (go & upd_cdc) begin
            c_q  <= ~dif[8];
            dc_q <= ~ldif[4];
        end else if (wr_stat) begin
            c_q  <= hwdata[`SSX_ST_C];
            dc_q <= hwdata[`SSX_ST_DC];
        end
        if (go & upd_z)
            z_q <= (res == `SSX_RST_BYTE);
        else if (wr_stat)
            z_q <= hwdata[`SSX_ST_Z];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sleep, power status and watchdog

// Flags reset high: not powered down, no time-out
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pd_n_q <= 1'b1;
        to_n_q <= 1'b1;
        slp_q  <= 1'b0;
    end else if (clk_en) begin
        if (do_slp) begin
            pd_n_q <= 1'b0;
            to_n_q <= 1'b1;
            slp_q  <= 1'b1;
        end else if (wr_stat) begin
            pd_n_q <= hwdata[`SSX_ST_PD];
            to_n_q <= hwdata[`SSX_ST_TO];
            // Software may only wake the core
            slp_q  <= slp_q & hwdata[`SSX_ST_SLP];
        end
    end
end

// Prescaler feeds counter; both halt while asleep
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wdog_q <= `SSX_WDOG_CLR;
        pre_q  <= `SSX_RST_PRE;
    end else if (clk_en) begin
        if (do_slp) begin
            wdog_q <= `SSX_WDOG_CLR;
            pre_q  <= `SSX_RST_PRE;
        end else if (!slp_q) begin
            pre_q <= pre_q + `SSX_PRE_ONE;
            if (pre_q == `SSX_PRE_MAX)
                wdog_q <= wdog_q + `SSX_PRE_ONE;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs and read data

wire [7:0] stat_v;

assign stat_v = {2'b00, slp_q, to_n_q, pd_n_q, z_q, dc_q, c_q};

// Registered outputs
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        acc_out    <= `SSX_RST_BYTE;
        file_we    <= 1'b0;
        file_addr  <= `SSX_RST_FADDR;
        file_wdata <= `SSX_RST_BYTE;
        wdt_clr    <= 1'b0;
        osc_stop   <= 1'b0;
    end else if (clk_en) begin
        acc_out  <= to_acc ? res : (wr_acc ? hwdata[7:0] : acc_q);
        file_we  <= to_file;
        wdt_clr  <= do_slp;
        osc_stop <= do_slp | (slp_q & ~(wr_stat & ~hwdata[`SSX_ST_SLP]));
        if (to_file) begin
            file_addr  <= faddr;
            file_wdata <= res;
        end
    end
end

// Read mux, loaded in the wait cycle
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= `SSX_ZERO32;
    end else if (clk_en) begin
        if (dph_q & ~dwr_q) begin
            case (dadr_q)
                `SSX_OFS_ACC:  hrdata <= {24'h000000, acc_q};
                `SSX_OFS_FILE: hrdata <= {24'h000000, fop_q};
                `SSX_OFS_STAT: hrdata <= {24'h000000, stat_v};
                `SSX_OFS_WDOG: hrdata <= {16'h0000, pre_q, wdog_q};
                default:       hrdata <= `SSX_ZERO32;
            endcase
        end
    end
end

endmodule

// ==== verif/ssx_exec_chk.sv ====
// Checker of bus timing and sleep side effects
`timescale 1ns/1ps
module ssx_exec_chk (
    input wire       hclk,
    input wire       hresetn,
    input wire       clk_en,
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hready,
    input wire       hreadyout,
    input wire [7:0] acc_out,
    input wire       file_we,
    input wire       wdt_clr,
    input wire       osc_stop
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake
    a_one_wait: assert property (hsel && hready && htrans[1] && clk_en
        |=> !hreadyout ##1 hreadyout) else $error("wait state count wrong");
    a_ready_back: assert property (!hreadyout |=> hreadyout) else $error("stall too long");
    // Sleep side effects
    a_sleep_clr_wdt: assert property ($rose(osc_stop) |-> wdt_clr)
        else $error("sleep without watchdog clear");
    a_wdt_pulse: assert property (wdt_clr |=> !wdt_clr) else $error("clear not a pulse");
    a_clr_stops_osc: assert property (wdt_clr |-> osc_stop ##1 osc_stop)
        else $error("oscillator not stopped");
    a_asleep_no_we: assert property (osc_stop && $past(osc_stop) |-> !file_we)
        else $error("write while asleep");
    // Destination routing
    a_we_pulse: assert property (file_we |=> !file_we) else $error("write not a pulse");
    a_we_keeps_acc: assert property (file_we |-> $stable(acc_out))
        else $error("accumulator changed on file write");
    c_sleep: cover property (wdt_clr);
    c_file_wr: cover property (file_we);
    c_wake: cover property ($fell(osc_stop));
endmodule

bind ssx_exec ssx_exec_chk i_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
    .acc_out(acc_out), .file_we(file_we), .wdt_clr(wdt_clr), .osc_stop(osc_stop));

// ==== verif/tb.sv ====
// Random and directed test of the execution block over its register bus
`timescale 1ns/1ps
`include "ssx_consts.vh"
module tb;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, file_we, wdt_clr, osc_stop, d, lt, ce;
    logic [31:0] haddr, hwdata, hrdata, seed, r;
    logic [1:0]  htrans;
    logic [7:0]  acc_out, file_wdata, w, f, k;
    logic [6:0]  file_addr;
    logic [2:0]  op;
    logic [10:0] e;
    logic [15:0] v;
    int          n_errors = 0;
    int          num_checks = 0;

    ssx_exec i_ssx_exec (.hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .acc_out(acc_out), .file_we(file_we), .file_addr(file_addr),
        .file_wdata(file_wdata), .wdt_clr(wdt_clr), .osc_stop(osc_stop));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 20 ns
    initial begin
        hclk = 0;
        forever #10 hclk = ~hclk;
    end

    // Random source
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected flags and result, flags as zero, digit carry, carry
    function automatic logic [10:0] calc(input logic [2:0] o, input logic [7:0] w, f, k,
                                         input logic [2:0] s);
        logic [7:0] a;
        logic [7:0] y;
        logic [2:0] fl;
        a = (o == `SSX_OP_LIT_SUB || o == `SSX_OP_LIT_XOR) ? k : f;
        fl = s;
        if (o > `SSX_OP_FILE_XOR) return {s, w}; // No-op keeps flags and accumulator
        y = a - w;
        if (o == `SSX_OP_NIB_SWAP) y = {a[3:0], a[7:4]};
        else if (o == `SSX_OP_LIT_XOR || o == `SSX_OP_FILE_XOR) y = a ^ w;
        else fl = {y == 8'h00, a[3:0] >= w[3:0], a >= w};
        if (o == `SSX_OP_LIT_XOR || o == `SSX_OP_FILE_XOR) fl[2] = (y == 8'h00);
        return {fl, y};
    endfunction

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One word transfer, address phase then data phase
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] dat);
        htrans <= 2'b10;
        haddr <= {26'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= dat;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task finish_test;
        if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        #400000;
        n_errors++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hresetn = 0;
        htrans = 0;
        haddr = 0;
        hwrite = 0;
        hwdata = 0;
        ce = 1;
        seed = 66;
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        bus(0, `SSX_OFS_STAT, 0);
        chk("stat_rst", r, 32'h18);
        bus(0, 6'h14, 0);
        chk("unmapped", r, 0);
        for (int i = 0; i < 150; i++) begin
            seed = nxt(seed);
            {d, k, f, w} = seed[24:0];
            op = 3'(i % 6 + 2);
            if (i < 10) f = w;
            if (i < 10) k = w;
            lt = (op == `SSX_OP_LIT_SUB || op == `SSX_OP_LIT_XOR || op == 3'h7);
            e = calc(op, w, f, k, seed[27:25]);
            bus(1, `SSX_OFS_ACC, {24'h0, w});
            bus(1, `SSX_OFS_FILE, {24'h0, f});
            bus(1, `SSX_OFS_STAT, {27'h3, seed[27:25]});
            bus(1, `SSX_OFS_CMD, {8'h0, k, 1'b0, f[6:0], 4'h0, d, op});
            chk("file_we", {31'h0, file_we}, {31'h0, d && !lt});
            bus(0, `SSX_OFS_ACC, 0);
            chk("acc", r, {24'h0, (d && !lt) ? w : e[7:0]});
            chk("acc_out", {24'h0, acc_out}, {24'h0, (d && !lt) ? w : e[7:0]});
            bus(0, `SSX_OFS_FILE, 0);
            chk("file", r, {24'h0, (d && !lt) ? e[7:0] : f});
            if (d && !lt) chk("fwd", {17'h0, file_addr, file_wdata}, {17'h0, f[6:0], e[7:0]});
            bus(0, `SSX_OFS_STAT, 0);
            chk("stat", r, {27'h3, e[10:8]});
        end
        // Sleep, refused command, then wake
        bus(1, `SSX_OFS_STAT, 32'h1d);
        bus(1, `SSX_OFS_CMD, {29'h0, `SSX_OP_SLEEP});
        chk("wdt_clr", {31'h0, wdt_clr}, 32'h1);
        chk("osc", {31'h0, osc_stop}, 32'h1);
        bus(0, `SSX_OFS_STAT, 0);
        chk("stat_slp", r, 32'h35);
        bus(0, `SSX_OFS_WDOG, 0);
        chk("wdog", r, 32'h0);
        bus(1, `SSX_OFS_ACC, 32'h3c);
        bus(1, `SSX_OFS_CMD, {8'h0, 8'hff, 13'h0, `SSX_OP_LIT_XOR});
        bus(0, `SSX_OFS_ACC, 0);
        chk("acc_slp", r, 32'h3c);
        bus(1, `SSX_OFS_STAT, 32'h1d);
        chk("wake", {31'h0, osc_stop}, 32'h0);
        // Clock enable low for five idle cycles freezes the counters
        bus(0, `SSX_OFS_WDOG, 0);
        v = {r[7:0], r[15:8]};
        ce <= 1'b0;
        repeat (5) @(posedge hclk);
        ce <= 1'b1;
        bus(0, `SSX_OFS_WDOG, 0);
        v = {r[7:0], r[15:8]} - v;
        chk("freeze", {16'h0, v}, 32'h3);
        finish_test();
    end
endmodule
